/* hw/csc_top.sv */
// Implementation choices: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
module csc_top #(
	parameter int ADDR_W = 8
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic power_on_release,
	input wire logic cell_undervoltage,
	input wire logic in_regulation,
	input wire logic warm_enough,
	input wire logic cool_enough,
	input wire logic timeout_event,
	input wire logic slope_event,
	output logic fast_mode,
	output logic gain_boost,
	output logic [csc_pkg::SENSE_W-1:0] sense_target_uv
);
	import csc_pkg::*;

	// ------------------------------------------------------------
	// Decode helpers
	// ------------------------------------------------------------
	function automatic logic is_mapped(input logic [ADDR_W-1:0] addr);
		logic [7:0] a;
		a = addr[7:0];
		is_mapped = (a == OFS_CTRL) || (a == OFS_STATUS) || (a == OFS_TARGET);
	endfunction

	// ------------------------------------------------------------
	// Input edges
	// ------------------------------------------------------------
	logic [IN_W-1:0] in_bus;
	logic [IN_W-1:0] in_rise;
	logic [IN_W-1:0] in_fall;

	assign in_bus[IN_POR] = power_on_release;
	assign in_bus[IN_UV] = cell_undervoltage;
	assign in_bus[IN_REG] = in_regulation;
	assign in_bus[IN_WARM] = warm_enough;
	assign in_bus[IN_COOL] = cool_enough;

	csc_edge #(
		.W(IN_W)
	) u_edge (
		.aclk(aclk),
		.aresetn(aresetn),
		.sig_in(in_bus),
		.rise(in_rise),
		.fall(in_fall)
	);

	// ------------------------------------------------------------
	// Control register fields
	// ------------------------------------------------------------
	logic [31:0] ctrl_ff;
	logic ctrl_force;
	logic ctrl_nocold;
	logic ctrl_nohot;
	logic [CTRL_SHIFT_W-1:0] ctrl_shift;

	assign ctrl_force = ctrl_ff[CTRL_FORCE_BIT];
	assign ctrl_nocold = ctrl_ff[CTRL_NOCOLD_BIT];
	assign ctrl_nohot = ctrl_ff[CTRL_NOHOT_BIT];
	assign ctrl_shift = ctrl_ff[CTRL_SHIFT_LSB +: CTRL_SHIFT_W];

	// ------------------------------------------------------------
	// Charge state
	// ------------------------------------------------------------
	csc_state_t state_ff;
	csc_state_t nxt_state;
	logic hot_ff;
	logic nxt_hot;
	logic cold_ff;
	logic nxt_cold;
	logic done_ff;
	logic nxt_done;
	logic [SENSE_W-1:0] target_ff;
	logic [SENSE_W-1:0] nxt_target;
	logic warm_ok;
	logic cool_ok;
	logic allow_fast;
	logic start_req;

	// The hot latch only clears on a new power-up, the done latch also when in_regulation rises, so a pack that
	// cooled or finished never slips back into fast on a marginal comparator.
	always_comb begin
		nxt_state = state_ff;
		nxt_hot = hot_ff;
		nxt_cold = cold_ff;
		nxt_done = done_ff;
		warm_ok = warm_enough | ctrl_nocold;
		cool_ok = cool_enough | ctrl_nohot;
		allow_fast = warm_ok && cool_ok && !cell_undervoltage && !hot_ff && !done_ff && !ctrl_force;
		start_req = 1'b0;
		if (!power_on_release) begin
			nxt_state = CSC_TRICKLE;
			nxt_hot = 1'b0;
			nxt_cold = 1'b0;
			nxt_done = 1'b0;
		end else if (in_rise[IN_POR]) begin
			nxt_hot = !cool_ok;
			nxt_cold = !warm_ok;
			nxt_done = timeout_event || slope_event;
			if (!cell_undervoltage && !in_regulation && warm_ok && cool_ok && !ctrl_force
				&& !timeout_event && !slope_event) begin
				nxt_state = CSC_FAST;
			end
		end else if (timeout_event || slope_event) begin
			nxt_state = CSC_TRICKLE;
			nxt_done = 1'b1;
		end else begin
			if (in_rise[IN_WARM]) begin
				nxt_cold = 1'b0;
			end
			if (in_rise[IN_REG]) begin
				nxt_done = 1'b0;
			end
			if (in_fall[IN_REG] && !cool_ok) begin
				nxt_hot = 1'b1;
			end
			if (in_fall[IN_COOL] && !ctrl_nohot) begin
				nxt_state = CSC_TRICKLE;
				nxt_hot = 1'b1;
			end else if (state_ff == CSC_FAST) begin
				if (in_rise[IN_UV] || in_rise[IN_REG] || ctrl_force) begin
					nxt_state = CSC_TRICKLE;
				end
			end else begin
				start_req = (in_fall[IN_UV] && !in_regulation)
					|| in_fall[IN_REG]
					|| (in_rise[IN_WARM] && cold_ff && !in_regulation);
				if (start_req && allow_fast) begin
					nxt_state = CSC_FAST;
				end
			end
		end
		case (nxt_state)
			CSC_FAST: begin
				nxt_target = SENSE_FAST_UV;
			end
			CSC_TRICKLE: begin
				nxt_target = SENSE_FAST_UV >> ctrl_shift;
			end
			default: begin
				nxt_target = SENSE_FAST_UV >> ctrl_shift;
			end
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_ff <= CSC_TRICKLE;
			hot_ff <= 1'b0;
			cold_ff <= 1'b0;
			done_ff <= 1'b0;
			target_ff <= SENSE_FAST_UV >> CTRL_RESET[CTRL_SHIFT_LSB +: CTRL_SHIFT_W];
		end else begin
			state_ff <= nxt_state;
			hot_ff <= nxt_hot;
			cold_ff <= nxt_cold;
			done_ff <= nxt_done;
			target_ff <= nxt_target;
		end
	end

	assign fast_mode = (state_ff == CSC_FAST);
	assign gain_boost = (state_ff != CSC_FAST);
	assign sense_target_uv = target_ff;

	// ------------------------------------------------------------
	// AXI4-Lite write channel
	// ------------------------------------------------------------
	logic aw_held_ff;
	logic nxt_aw_held;
	logic [ADDR_W-1:0] aw_addr_ff;
	logic [ADDR_W-1:0] nxt_aw_addr;
	logic w_held_ff;
	logic nxt_w_held;
	logic [31:0] w_data_ff;
	logic [31:0] nxt_w_data;
	logic [3:0] w_strb_ff;
	logic [3:0] nxt_w_strb;
	logic bvalid_ff;
	logic nxt_bvalid;
	logic [1:0] bresp_ff;
	logic [1:0] nxt_bresp;
	logic [31:0] nxt_ctrl;
	logic [31:0] strb_mask;

	// Address and data are parked separately, so either may arrive first;
	// the write commits only once both are held and no response is pending.
	always_comb begin
		nxt_aw_held = aw_held_ff;
		nxt_aw_addr = aw_addr_ff;
		nxt_w_held = w_held_ff;
		nxt_w_data = w_data_ff;
		nxt_w_strb = w_strb_ff;
		nxt_bvalid = bvalid_ff;
		nxt_bresp = bresp_ff;
		nxt_ctrl = ctrl_ff;
		strb_mask = {{8{w_strb_ff[3]}}, {8{w_strb_ff[2]}}, {8{w_strb_ff[1]}}, {8{w_strb_ff[0]}}};
		if (s_axi_awvalid && s_axi_awready) begin
			nxt_aw_held = 1'b1;
			nxt_aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			nxt_w_held = 1'b1;
			nxt_w_data = s_axi_wdata;
			nxt_w_strb = s_axi_wstrb;
		end
		if (aw_held_ff && w_held_ff && !bvalid_ff) begin
			nxt_aw_held = 1'b0;
			nxt_w_held = 1'b0;
			nxt_bvalid = 1'b1;
			nxt_bresp = is_mapped(aw_addr_ff) ? RESP_OKAY : RESP_SLVERR;
			if (aw_addr_ff[7:0] == OFS_CTRL) begin
				nxt_ctrl = ((ctrl_ff & ~strb_mask) | (w_data_ff & strb_mask)) & CTRL_MASK;
			end
		end
		if (bvalid_ff && s_axi_bready) begin
			nxt_bvalid = 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_ff <= 1'b0;
			aw_addr_ff <= '0;
			w_held_ff <= 1'b0;
			w_data_ff <= 32'h0000_0000;
			w_strb_ff <= 4'h0;
			bvalid_ff <= 1'b0;
			bresp_ff <= RESP_OKAY;
			ctrl_ff <= CTRL_RESET;
		end else begin
			aw_held_ff <= nxt_aw_held;
			aw_addr_ff <= nxt_aw_addr;
			w_held_ff <= nxt_w_held;
			w_data_ff <= nxt_w_data;
			w_strb_ff <= nxt_w_strb;
			bvalid_ff <= nxt_bvalid;
			bresp_ff <= nxt_bresp;
			ctrl_ff <= nxt_ctrl;
		end
	end

	assign s_axi_awready = !aw_held_ff && !bvalid_ff;
	assign s_axi_wready = !w_held_ff && !bvalid_ff;
	assign s_axi_bvalid = bvalid_ff;
	assign s_axi_bresp = bresp_ff;

	// ------------------------------------------------------------
	// AXI4-Lite read channel
	// ------------------------------------------------------------
	logic rvalid_ff;
	logic nxt_rvalid;
	logic [31:0] rdata_ff;
	logic [31:0] nxt_rdata;
	logic [1:0] rresp_ff;
	logic [1:0] nxt_rresp;
	logic [31:0] status_word;

	always_comb begin
		status_word = 32'h0000_0000;
		status_word[ST_FAST_BIT] = fast_mode;
		status_word[ST_HOT_BIT] = hot_ff;
		status_word[ST_COLD_BIT] = cold_ff;
		status_word[ST_DONE_BIT] = done_ff;
		status_word[ST_IN_LSB +: IN_W] = in_bus;
		nxt_rvalid = rvalid_ff;
		nxt_rdata = rdata_ff;
		nxt_rresp = rresp_ff;
		if (s_axi_arvalid && s_axi_arready) begin
			nxt_rvalid = 1'b1;
			nxt_rresp = is_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
			case (s_axi_araddr[7:0])
				OFS_CTRL: begin
					nxt_rdata = ctrl_ff;
				end
				OFS_STATUS: begin
					nxt_rdata = status_word;
				end
				OFS_TARGET: begin
					nxt_rdata = {{(32 - SENSE_W){1'b0}}, target_ff};
				end
				default: begin
					nxt_rdata = 32'h0000_0000;
				end
			endcase
		end else if (rvalid_ff && s_axi_rready) begin
			nxt_rvalid = 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_ff <= 1'b0;
			rdata_ff <= 32'h0000_0000;
			rresp_ff <= RESP_OKAY;
		end else begin
			rvalid_ff <= nxt_rvalid;
			rdata_ff <= nxt_rdata;
			rresp_ff <= nxt_rresp;
		end
	end

	assign s_axi_arready = !rvalid_ff;
	assign s_axi_rvalid = rvalid_ff;
	assign s_axi_rdata = rdata_ff;
	assign s_axi_rresp = rresp_ff;

endmodule

/* hw/csc_pkg.sv */
package csc_pkg;

	// ------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	localparam logic [7:0] OFS_TARGET = 8'h08;

	localparam int CTRL_FORCE_BIT = 0;
	localparam int CTRL_NOCOLD_BIT = 1;
	localparam int CTRL_NOHOT_BIT = 2;
	localparam int CTRL_SHIFT_LSB = 4;
	localparam int CTRL_SHIFT_W = 3;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0040;
	localparam logic [31:0] CTRL_MASK = 32'h0000_0077;

	localparam int ST_FAST_BIT = 0;
	localparam int ST_HOT_BIT = 1;
	localparam int ST_COLD_BIT = 2;
	localparam int ST_DONE_BIT = 3;
	localparam int ST_IN_LSB = 4;

	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	// ------------------------------------------------------------
	// Analogue targets
	// ------------------------------------------------------------
	localparam int SENSE_W = 18;
	localparam logic [17:0] SENSE_FAST_UV = 18'h3_D090;
	localparam logic [9:0] CELL_LOCKOUT_MV = 10'h190;

	// ------------------------------------------------------------
	// Input bundle positions and states
	// ------------------------------------------------------------
	localparam int IN_W = 5;
	localparam int IN_POR = 0;
	localparam int IN_UV = 1;
	localparam int IN_REG = 2;
	localparam int IN_WARM = 3;
	localparam int IN_COOL = 4;

	typedef enum logic [1:0] {
		CSC_TRICKLE = 2'b01,
		CSC_FAST = 2'b10
	} csc_state_t;

endpackage

/* hw/csc_edge.sv */
`timescale 1ns/1ps
module csc_edge #(
	parameter int W = 5
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [W-1:0] sig_in,
	output logic [W-1:0] rise,
	output logic [W-1:0] fall
);

	logic [W-1:0] prev_ff;
	logic [W-1:0] nxt_prev;

	// Previous levels reset low, so a level already high at release reads as a rise.
	always_comb begin
		nxt_prev = sig_in;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			prev_ff <= '0;
		end else begin
			prev_ff <= nxt_prev;
		end
	end

	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_edge
			assign rise[i] = sig_in[i] & ~prev_ff[i];
			assign fall[i] = ~sig_in[i] & prev_ff[i];
		end
	endgenerate

endmodule

/* bench/csc_properties.sv */
`timescale 1ns/1ps
// ----------------------------------------
// Charge state properties
// ----------------------------------------
module csc_properties
	import csc_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic power_on_release,
	input wire logic cell_undervoltage,
	input wire logic in_regulation,
	input wire logic warm_enough,
	input wire logic cool_enough,
	input wire logic timeout_event,
	input wire logic slope_event,
	input wire logic fast_mode,
	input wire logic gain_boost,
	input wire logic [csc_pkg::SENSE_W-1:0] sense_target_uv
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence s_ready;
		!cell_undervoltage && !in_regulation && warm_enough && cool_enough;
	endsequence
	// Skips the first edge after reset, where the edge detectors still hold their reset value.
	sequence s_steady;
		power_on_release && $past(power_on_release) && $past(aresetn);
	endsequence
	property p_one;
		gain_boost == !fast_mode;
	endproperty
	a_one: assert property (p_one) else $error("gain and state disagree");
	property p_por_low;
		!power_on_release |=> !fast_mode;
	endproperty
	a_por_low: assert property (p_por_low) else $error("fast while held");
	property p_start;
		$rose(power_on_release) ##0 s_ready ##0 !(timeout_event || slope_event) |=> fast_mode;
	endproperty
	a_start: assert property (p_start) else $error("no fast at power-up");
	property p_uv;
		!fast_mode && cell_undervoltage |=> !fast_mode;
	endproperty
	a_uv: assert property (p_uv) else $error("fast under lockout");
	property p_temp;
		!fast_mode && !(warm_enough && cool_enough) |=> !fast_mode;
	endproperty
	a_temp: assert property (p_temp) else $error("fast out of window");
	property p_term;
		(timeout_event || slope_event) |=> !fast_mode;
	endproperty
	a_term: assert property (p_term) else $error("event ignored");
	property p_exit;
		fast_mode && ($rose(cell_undervoltage) || $rose(in_regulation) || $fell(cool_enough)) |=> !fast_mode;
	endproperty
	a_exit: assert property (p_exit) else $error("fast exit missed");
	property p_stay;
		s_steady ##0 (!fast_mode && !$fell(in_regulation) && !$fell(cell_undervoltage) && !$rose(warm_enough))
			|=> !fast_mode;
	endproperty
	a_stay: assert property (p_stay) else $error("fast without cause");
	property p_fast_tgt;
		fast_mode |-> sense_target_uv == SENSE_FAST_UV;
	endproperty
	a_fast_tgt: assert property (p_fast_tgt) else $error("fast target wrong");
	property p_trk_tgt;
		!fast_mode |-> sense_target_uv < SENSE_FAST_UV;
	endproperty
	a_trk_tgt: assert property (p_trk_tgt) else $error("trickle target high");
endmodule

bind csc_top csc_properties u_props (.aclk(aclk), .aresetn(aresetn), .power_on_release(power_on_release),
	.cell_undervoltage(cell_undervoltage), .in_regulation(in_regulation), .warm_enough(warm_enough),
	.cool_enough(cool_enough), .timeout_event(timeout_event), .slope_event(slope_event),
	.fast_mode(fast_mode), .gain_boost(gain_boost), .sense_target_uv(sense_target_uv));

/* bench/csc_pack_model.sv */
`timescale 1ns/1ps
// ----------------------------------------
// Pack and comparator model
// ----------------------------------------
// Temperature code: 0 cold, 1 in window, 2 hot.
module csc_pack_model (
	input wire logic aclk,
	input wire logic present,
	input wire logic [1:0] temp,
	input wire logic low_cell,
	output logic cell_undervoltage,
	output logic in_regulation,
	output logic warm_enough,
	output logic cool_enough
);
	// Without a pack the regulator holds the output up, so no lockout shows.
	always_ff @(posedge aclk) begin
		cell_undervoltage <= present && low_cell;
		in_regulation <= !present;
		warm_enough <= temp != 2'd0;
		cool_enough <= temp != 2'd2;
	end
endmodule

/* bench/csc_top_tb_top.sv */
`timescale 1ns/1ps
// ----------------------------------------
// Bench
// ----------------------------------------
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin failures++; \
	$display("MISMATCH %s exp %0h got %0h", nm, e, g); end end
module csc_top_tb_top;
	import csc_pkg::*;
	logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata, d;
	logic [1:0] bresp, rresp, r, temp;
	logic por, uv, reg_on, warm, cool, tmo, slope, fast, boost, present, low_cell;
	logic [SENSE_W-1:0] tgt;
	int failures = 0, check_count = 0, shift = 4;
	csc_top dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .power_on_release(por), .cell_undervoltage(uv), .in_regulation(reg_on),
		.warm_enough(warm), .cool_enough(cool), .timeout_event(tmo), .slope_event(slope),
		.fast_mode(fast), .gain_boost(boost), .sense_target_uv(tgt));
	csc_pack_model pack_u (.aclk(aclk), .present(present), .temp(temp), .low_cell(low_cell),
		.cell_undervoltage(uv), .in_regulation(reg_on), .warm_enough(warm), .cool_enough(cool));
	task automatic wrap_up;
		if (failures == 0 && check_count > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		logic aw, w;
		@(posedge aclk);
		awaddr <= a; wdata <= v; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
		aw = 1'b1; w = 1'b1;
		while (aw || w) begin
			@(posedge aclk);
			if (awready) begin aw = 1'b0; awvalid <= 1'b0; end
			if (wready) begin w = 1'b0; wvalid <= 1'b0; end
		end
		do @(posedge aclk); while (!bvalid);
		r = bresp; bready <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge aclk);
		araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
		do @(posedge aclk); while (!arready);
		arvalid <= 1'b0;
		do @(posedge aclk); while (!rvalid);
		d = rdata; r = rresp; rready <= 1'b0;
	endtask
	// Model adds one cycle and the controller one more, so three edges settle everything.
	task automatic go(input logic p, input logic pr, input logic [1:0] t, input logic lc);
		@(posedge aclk);
		por <= p; present <= pr; temp <= t; low_cell <= lc;
		repeat (3) @(posedge aclk);
		#1;
	endtask
	task automatic evt(input logic s);
		@(posedge aclk);
		slope <= s; tmo <= !s;
		@(posedge aclk);
		slope <= 1'b0; tmo <= 1'b0;
		repeat (2) @(posedge aclk);
		#1;
	endtask
	task automatic ex(input logic f);
		`CHK("fast_mode", f, fast)
		`CHK("gain_boost", !f, boost)
		`CHK("target", f ? SENSE_FAST_UV : SENSE_FAST_UV >> shift, tgt)
	endtask
	task automatic t_powerup;
		go(0, 1, 1, 0); ex(0);
		go(1, 1, 1, 0); ex(1);
		go(0, 1, 1, 0); ex(0);
		@(posedge aclk);
		por <= 1'b1;
		slope <= 1'b1;
		@(posedge aclk);
		slope <= 1'b0;
		repeat (2) @(posedge aclk);
		#1 ex(0);
		go(0, 1, 1, 0); go(1, 1, 1, 0); evt(1); ex(0);
		repeat (20) @(posedge aclk); go(1, 1, 1, 1); go(1, 1, 1, 0); ex(0);
	endtask
	task automatic t_uv;
		go(0, 1, 1, 1); go(1, 1, 1, 1); ex(0);
		go(1, 1, 1, 0); ex(1);
		go(1, 1, 1, 1); ex(0);
	endtask
	task automatic t_insert;
		go(0, 0, 1, 0); go(1, 0, 1, 0); ex(0);
		go(1, 1, 1, 0); ex(1);
		go(1, 0, 1, 0); ex(0);
		go(1, 1, 0, 0); ex(0);
	endtask
	task automatic t_cold;
		go(0, 1, 0, 0); go(1, 1, 0, 0); ex(0);
		go(1, 1, 1, 0); ex(1);
		go(1, 1, 0, 0); ex(1);
		wr(OFS_CTRL, 32'h0000_0041); wr(OFS_CTRL, CTRL_RESET);
		#1 ex(0);
		go(1, 1, 1, 0); ex(0);
		go(0, 1, 1, 0); go(1, 1, 1, 0); evt(0); ex(0);
	endtask
	task automatic t_hot;
		go(0, 1, 2, 0); go(1, 1, 2, 0); go(1, 1, 1, 0); ex(0);
		go(1, 0, 1, 0); go(1, 1, 1, 0); ex(0);
		go(0, 1, 1, 0); go(1, 1, 1, 0); go(1, 1, 2, 0); ex(0);
		go(1, 1, 1, 0); ex(0);
		go(1, 0, 1, 0); go(1, 1, 1, 0); ex(0);
		go(0, 1, 1, 0); go(1, 1, 1, 0); ex(1);
	endtask
	task automatic t_regs;
		rd(OFS_CTRL); `CHK("ctrl", CTRL_RESET, d)
		wr(OFS_CTRL, 32'h0000_0041); `CHK("bresp", RESP_OKAY, r)
		#1 ex(0);
		wr(OFS_CTRL, 32'h0000_0030); shift = 3;
		#1 ex(0);
		rd(OFS_TARGET); `CHK("target_reg", 32'h0000_7A12, d)
		rd(8'h0C); `CHK("rresp", RESP_SLVERR, r)
		wr(OFS_CTRL, CTRL_RESET); shift = 4;
	endtask
	initial begin
		aclk = 1'b0;
		forever #4 aclk = ~aclk;
	end
	initial begin
		repeat (20000) @(posedge aclk);
		failures++;
		wrap_up();
	end
	initial begin
		aresetn = 0; awvalid = 0; wvalid = 0; bready = 0; arvalid = 0; rready = 0;
		awaddr = 0; araddr = 0; wdata = 0; por = 0; tmo = 0; slope = 0;
		present = 1; temp = 1; low_cell = 0;
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		t_powerup();
		t_uv();
		t_insert();
		t_cold();
		t_hot();
		t_regs();
		wrap_up();
	end
endmodule
